// *** hw/sdrtb_ctl.v ***
// How it works
// - Prescaler divides the bus clock by the 8-bit divisor field.
// - The prescaler tick paces both the refresh engine and 32-bit counter.
// - Divisor field resets to hex 64, right for a 100 MHz clock.
// - Refresh lags only if divisor exceeds clock MHz; small divisor refreshes faster.
// - Double-rate bit halves the refresh interval; cleared keeps it normal.
// - Power-up flag is set by reset and cleared only by writing one.
// - Refresh inhibit holds the refresh engine and its counters cleared.
// - Inhibit changes wait until an ongoing refresh cycle finishes.
// - Check-bit access steers memory reads and writes to stored check bits.
// - Check bits travel on lanes D0-D7, one byte per 64 data bits.
// - Interrupt flag sets on an enabled event, clears on reset or write one.
// - Correction disable returns raw data; write merges skip correction.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "sdrtb_regs.vh"

module sdrtb_ctl (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Register port.
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Error events from the logger, one-cycle pulses.
  input wire evt_addr_par,
  input wire evt_sbe_roll,
  input wire evt_data_par,
  input wire evt_sbe_log,
  input wire evt_mbe_log,
  input wire mbe_on_bus,
  // Processor read path from the array.
  input wire mem_rd_valid,
  input wire [63:0] arr_data,
  input wire [63:0] corr_data,
  input wire [7:0] arr_cb,
  output reg [63:0] mem_rdata,
  output reg mem_rvalid,
  // Processor write path to the array.
  input wire mem_wr,
  input wire [63:0] mem_wdata,
  output reg data_wr,
  output reg cb_wr,
  output reg [7:0] cb_wdata,
  output reg merge_correct_en,
  output reg cb_access,
  // Refresh and timebase.
  output reg refresh_cmd,
  output reg refresh_busy,
  output reg [31:0] tick_count,
  // Notification.
  output reg irq,
  output reg mchk_pulse
);

  // Register state.
  reg [7:0] divisor;
  reg drr;
  reg por_flag;
  reg refdis;
  reg refdis_pend;
  reg refdis_pend_vld;
  reg rwcb;
  reg derc;
  reg [`SDRTB_NUM_EVT-1:0] evt_en;
  reg int_flag;
  reg mchk_en;
  reg [`SDRTB_NUM_EVT-1:0] evt_status;
  reg div_restart;

  // Engine wires.
  wire tick;
  wire eng_start;
  wire eng_busy;
  wire [`SDRTB_NUM_EVT-1:0] evt_in;

  // Address decode used by both the write and read paths.
  // Code three covers the counter and every unmapped word; the read path splits it.
  function [1:0] reg_sel;
    input [31:0] addr;
    begin
      if (addr == `SDRTB_ADDR_CLK_PRESCALE) begin
        reg_sel = 2'h0;
      end else if (addr == `SDRTB_ADDR_EVT_STATUS) begin
        reg_sel = 2'h1;
      end else if (addr == `SDRTB_ADDR_ECC_CONTROL) begin
        reg_sel = 2'h2;
      end else begin
        reg_sel = 2'h3;
      end
    end
  endfunction

  // Write decodes; each register sees its strobe only on an exact address match,
  // so nearby addresses never disturb the fields.
  wire wr_clk = reg_wr && reg_sel(reg_addr) == 2'h0;
  wire wr_evt = reg_wr && reg_sel(reg_addr) == 2'h1;
  wire wr_ecc = reg_wr && reg_sel(reg_addr) == 2'h2;

  // Event vector in the shared status and enable layout.
  assign evt_in = {evt_addr_par, evt_sbe_roll, evt_data_par, evt_sbe_log, evt_mbe_log};

  // Timebase: the tick paces the counter and the refresh engine alike.
  sdrtb_prescaler u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .divisor(divisor),
    .restart(div_restart),
    .tick(tick)
  );

  // The inhibit is fed as the engine's clear, so all its state is held at zero.
  sdrtb_refresh u_refresh (
    .clk(clk),
    .rst_n(rst_n),
    .clear(refdis),
    .tick(tick),
    .drr(drr),
    .ref_start(eng_start),
    .busy(eng_busy)
  );

  // Clock prescale control; the restart lands in the same cycle as the new divisor.
  // A restart costs one partial tick, but a new divisor never waits behind a slow count.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor <= `SDRTB_DIV_RESET;
      drr <= 1'b0;
      por_flag <= 1'b1;
      div_restart <= 1'b0;
    end else begin
      div_restart <= wr_clk;
      if (wr_clk) begin
        divisor <= reg_wdata[`SDRTB_DIV_HI:`SDRTB_DIV_LO];
        drr <= reg_wdata[`SDRTB_DRR_BIT];
        if (reg_wdata[`SDRTB_POR_BIT]) begin
          por_flag <= 1'b0;
        end
      end
    end
  end

  // Refresh inhibit is staged while a refresh cycle is active, so the array
  // never sees a cycle cut short; other fields take effect at once.
  // A write that lands while nothing is busy drops any staged value, so the last write wins.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refdis <= 1'b0;
      refdis_pend <= 1'b0;
      refdis_pend_vld <= 1'b0;
    end else if (wr_ecc) begin
      if (eng_busy) begin
        refdis_pend <= reg_wdata[`SDRTB_REFDIS_BIT];
        refdis_pend_vld <= 1'b1;
      end else begin
        refdis <= reg_wdata[`SDRTB_REFDIS_BIT];
        refdis_pend_vld <= 1'b0;
      end
    end else if (refdis_pend_vld && !eng_busy) begin
      refdis <= refdis_pend;
      refdis_pend_vld <= 1'b0;
    end
  end

  // Remaining ECC control fields.
  // The int bit lives with the sticky flags below, since it is write-one-to-clear.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rwcb <= 1'b0;
      derc <= `SDRTB_DERC_RESET;
      evt_en <= {`SDRTB_NUM_EVT{1'b0}};
      mchk_en <= 1'b0;
    end else if (wr_ecc) begin
      rwcb <= reg_wdata[`SDRTB_RWCB_BIT];
      derc <= reg_wdata[`SDRTB_DERC_BIT];
      evt_en <= reg_wdata[`SDRTB_EN_HI:`SDRTB_EN_LO];
      mchk_en <= reg_wdata[`SDRTB_MCHK_EN_BIT];
    end
  end

  // Sticky flags; a new event in the cycle of a clearing write wins.
  // Losing an event to a racing clear would hide an error, so the clear gives way.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_flag <= 1'b0;
      evt_status <= {`SDRTB_NUM_EVT{1'b0}};
    end else begin
      if (|(evt_in & evt_en)) begin
        int_flag <= 1'b1;
      end else if (wr_ecc && reg_wdata[`SDRTB_INT_BIT]) begin
        int_flag <= 1'b0;
      end
      evt_status <= evt_in | (evt_status & ~(wr_evt ? reg_wdata[`SDRTB_NUM_EVT-1:0] :
        {`SDRTB_NUM_EVT{1'b0}}));
    end
  end

  // Interrupt and machine check outputs; scrub errors never reach mbe_on_bus.
  // The event term lets irq rise one cycle after the event rather than two.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      mchk_pulse <= 1'b0;
    end else begin
      irq <= int_flag | (|(evt_in & evt_en));
      mchk_pulse <= mbe_on_bus & mchk_en;
    end
  end

  // Free-running counter advanced by the prescaler tick.
  // It wraps silently; software works with differences, so the wrap is harmless.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= 32'h00000000;
    end else if (tick) begin
      tick_count <= tick_count + 32'h00000001;
    end
  end

  // Refresh command mirrors the engine, registered once more for the array.
  // The extra stage keeps the array side off the engine's compare logic.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_cmd <= 1'b0;
      refresh_busy <= 1'b0;
    end else begin
      refresh_cmd <= eng_start;
      refresh_busy <= eng_busy;
    end
  end

  // Read path: check-bit access returns the byte on D0-D7 with upper lanes zero;
  // correction disable hands back the raw array word.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= 64'h0000000000000000;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rvalid <= mem_rd_valid;
      if (mem_rd_valid) begin
        if (rwcb) begin
          mem_rdata <= {56'h00000000000000, arr_cb};
        end else if (derc) begin
          mem_rdata <= arr_data;
        end else begin
          mem_rdata <= corr_data;
        end
      end
    end
  end

  // Write path: in check-bit mode the data word is left alone and only the
  // check byte is written; check bits are still generated downstream otherwise.
  // The upper write lanes are ignored in check-bit mode; only D0-D7 matter.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_wr <= 1'b0;
      cb_wr <= 1'b0;
      cb_wdata <= 8'h00;
      merge_correct_en <= 1'b0;
      cb_access <= 1'b0;
    end else begin
      data_wr <= mem_wr & ~rwcb;
      cb_wr <= mem_wr & rwcb;
      if (mem_wr && rwcb) begin
        cb_wdata <= mem_wdata[7:0];
      end
      merge_correct_en <= ~derc;
      cb_access <= rwcb;
    end
  end

  // Register read, one cycle after the strobe; unmapped addresses read zero.
  // Clearing the data between reads keeps stale values off the read port.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_sel(reg_addr) == 2'h0) begin
        reg_rdata <= {divisor, 7'h00, drr, 15'h0000, por_flag};
      end else if (reg_sel(reg_addr) == 2'h1) begin
        reg_rdata <= {27'h0000000, evt_status};
      end else if (reg_sel(reg_addr) == 2'h2) begin
        reg_rdata <= {5'h00, refdis, rwcb, derc, 3'h0, evt_en, int_flag,
          14'h0000, mchk_en};
      end else if (reg_addr == `SDRTB_ADDR_TICK_COUNT) begin
        reg_rdata <= tick_count;
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// *** hw/sdrtb_prescaler.v ***
`timescale 1ns/1ps
`include "sdrtb_regs.vh"

module sdrtb_prescaler (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Divisor and restart.
  input wire [7:0] divisor,
  input wire restart,
  // One-cycle tick output.
  output reg tick
);

  reg [7:0] count;

  // Down counter; a divisor of zero or one ticks every cycle.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (restart) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (count == 8'h00) begin
      tick <= 1'b1;
      count <= (divisor <= 8'h01) ? 8'h00 : divisor - 8'h01;
    end else begin
      tick <= 1'b0;
      count <= count - 8'h01;
    end
  end

endmodule

// *** hw/sdrtb_refresh.v ***
`timescale 1ns/1ps
`include "sdrtb_regs.vh"

module sdrtb_refresh (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Control.
  input wire clear,
  input wire tick,
  input wire drr,
  // Refresh command to the array side.
  output reg ref_start,
  output reg busy
);

  localparam integer CYC_LEN_FULL = `SDRTB_REF_CYCLES;
  localparam [3:0] CYC_LEN = CYC_LEN_FULL[3:0];

  reg [15:0] acc;
  reg [3:0] cyc;
  reg [15:0] next_acc;
  reg [15:0] step;

  // Each tick adds the elapsed nanoseconds; doubling the step halves the interval.
  always @* begin
    step = `SDRTB_TICK_NS;
    if (drr) begin
      step = {step[14:0], 1'b0};
    end
    next_acc = tick ? acc + step : acc;
  end

  // The remainder is carried so the average interval is exact, not rounded to ticks.
  // A clear that meets a cycle just started waits for its end, so none is cut short.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 16'h0000;
      cyc <= 4'h0;
      ref_start <= 1'b0;
      busy <= 1'b0;
    end else if (clear && !busy) begin
      acc <= 16'h0000;
      cyc <= 4'h0;
      ref_start <= 1'b0;
      busy <= 1'b0;
    end else if (!busy && next_acc >= `SDRTB_REF_PERIOD_NS) begin
      acc <= next_acc - `SDRTB_REF_PERIOD_NS;
      cyc <= CYC_LEN;
      ref_start <= 1'b1;
      busy <= 1'b1;
    end else begin
      acc <= next_acc;
      ref_start <= 1'b0;
      if (busy) begin
        cyc <= cyc - 4'h1;
        if (cyc == 4'h1) begin
          busy <= 1'b0;
        end
      end
    end
  end

endmodule

// *** hw/sdrtb_regs.vh ***
`ifndef SDRTB_REGS_VH
`define SDRTB_REGS_VH

// Register byte addresses on the register port.
`define SDRTB_ADDR_CLK_PRESCALE 32'hfef80020
`define SDRTB_ADDR_EVT_STATUS 32'hfef80024
`define SDRTB_ADDR_ECC_CONTROL 32'hfef80028
`define SDRTB_ADDR_TICK_COUNT 32'hfef80040

// Clock prescale control fields (bit 0 is the least significant bit here).
`define SDRTB_DIV_HI 31
`define SDRTB_DIV_LO 24
`define SDRTB_DRR_BIT 16
`define SDRTB_POR_BIT 0
`define SDRTB_DIV_RESET 8'h64

// ECC control fields.
`define SDRTB_REFDIS_BIT 26
`define SDRTB_RWCB_BIT 25
`define SDRTB_DERC_BIT 24
`define SDRTB_EN_HI 20
`define SDRTB_EN_LO 16
`define SDRTB_INT_BIT 15
`define SDRTB_MCHK_EN_BIT 0
`define SDRTB_DERC_RESET 1'b1

// Event layout, shared by the event status register and the enable field.
`define SDRTB_EVT_ADDR_PAR 4
`define SDRTB_EVT_SBE_ROLL 3
`define SDRTB_EVT_DATA_PAR 2
`define SDRTB_EVT_SBE_LOG 1
`define SDRTB_EVT_MBE_LOG 0
`define SDRTB_NUM_EVT 5

// Timing: clock period, tick period and refresh period in nanoseconds.
`define SDRTB_CLK_PERIOD_NS 4
`define SDRTB_TICK_NS 16'd1000
`define SDRTB_REF_PERIOD_NS 16'd15600
`define SDRTB_REF_CYC_NS 32
`define SDRTB_REF_CYCLES (((`SDRTB_REF_CYC_NS) + (`SDRTB_CLK_PERIOD_NS) - 1) / (`SDRTB_CLK_PERIOD_NS))

`endif

// *** tb/sdrtb_array_model.sv ***
`timescale 1ns/1ps
module sdrtb_array_model (
  // Clock.
  input wire clk,
  // Writes from the controller.
  input wire data_wr,
  input wire cb_wr,
  input wire [63:0] mem_wdata,
  input wire [7:0] cb_wdata,
  // Reads towards the controller.
  output reg [63:0] arr_data = 64'h0123456789abcdef,
  output reg [63:0] corr_data,
  output reg [7:0] arr_cb = 8'h5a
);
  // The corrected word differs from the raw one in bit 0, so a read shows its path.
  always @* corr_data = arr_data ^ 64'h1;
  // Check byte is stored apart from the word, as lanes D0-D7 carry only it.
  always @(posedge clk) begin
    if (data_wr) arr_data <= mem_wdata ^ 64'h1;
    if (cb_wr) arr_cb <= cb_wdata;
  end
endmodule

// *** tb/sdrtb_ctl_sva.sv ***
`timescale 1ns/1ps
`include "sdrtb_regs.vh"
module sdrtb_ctl_sva (
  // Clock, reset and register port.
  input wire clk,
  input wire rst_n,
  input wire [31:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [31:0] reg_rdata,
  // Memory path, refresh and notification.
  input wire mem_wr,
  input wire mem_rd_valid,
  input wire mbe_on_bus,
  input wire mem_rvalid,
  input wire data_wr,
  input wire cb_wr,
  input wire refresh_busy,
  input wire irq,
  input wire mchk_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wr_one_path: assert property (mem_wr |=> data_wr ^ cb_wr)
    else $error("write steered to both or neither path");
  a_wr_has_cause: assert property ((data_wr || cb_wr) |-> $past(mem_wr))
    else $error("array write without a request");
  a_rd_answer: assert property (mem_rd_valid |=> mem_rvalid)
    else $error("read answer missing");
  a_busy_whole: assert property ($rose(refresh_busy) |-> refresh_busy [*8])
    else $error("refresh cycle cut short");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_clk_rsvd: assert property (reg_rd && reg_addr == `SDRTB_ADDR_CLK_PRESCALE
    |=> (reg_rdata & 32'h00fefffe) == 32'h0)
    else $error("prescale reserved bits not zero");
  a_ecc_rsvd: assert property (reg_rd && reg_addr == `SDRTB_ADDR_ECC_CONTROL
    |=> (reg_rdata & 32'hf8e07ffe) == 32'h0)
    else $error("ecc reserved bits not zero");
  a_irq_sticky: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
    else $error("interrupt dropped without a write");
  a_mchk_cause: assert property (mchk_pulse |-> $past(mbe_on_bus))
    else $error("machine check without an error");
endmodule
bind sdrtb_ctl sdrtb_ctl_sva i_sva (.clk, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_rdata,
  .mem_wr, .mem_rd_valid, .mbe_on_bus, .mem_rvalid, .data_wr, .cb_wr, .refresh_busy, .irq,
  .mchk_pulse);

// *** tb/sdrtb_ctl_tb_top.sv ***
`timescale 1ns/1ps
`include "sdrtb_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module sdrtb_ctl_tb_top;
  reg clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, mbe_on_bus = 0, mem_rd_valid = 0, mem_wr = 0;
  reg [31:0] reg_addr = 0, reg_wdata = 0, rd_val;
  reg [4:0] ev = 0;
  reg [63:0] mem_wdata = 0;
  wire [63:0] arr_data, corr_data, mem_rdata;
  wire [7:0] arr_cb, cb_wdata;
  wire [31:0] reg_rdata, tick_count;
  wire mem_rvalid, data_wr, cb_wr, merge_correct_en, cb_access, refresh_cmd;
  wire refresh_busy, irq, mchk_pulse;
  integer failures = 0, checked = 0, n, i;
  localparam CP = `SDRTB_ADDR_CLK_PRESCALE, EC = `SDRTB_ADDR_ECC_CONTROL;
  localparam ST = `SDRTB_ADDR_EVT_STATUS;
  always #2 clk = ~clk;
  sdrtb_ctl i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .evt_addr_par(ev[4]), .evt_sbe_roll(ev[3]), .evt_data_par(ev[2]), .evt_sbe_log(ev[1]),
    .evt_mbe_log(ev[0]), .mbe_on_bus, .mem_rd_valid, .arr_data, .corr_data, .arr_cb,
    .mem_rdata, .mem_rvalid, .mem_wr, .mem_wdata, .data_wr, .cb_wr, .cb_wdata,
    .merge_correct_en, .cb_access, .refresh_cmd, .refresh_busy, .tick_count, .irq,
    .mchk_pulse);
  sdrtb_array_model i_arr (.clk, .data_wr, .cb_wr, .mem_wdata, .cb_wdata, .arr_data,
    .corr_data, .arr_cb);
  // Register writes and reads are one-cycle strobes; read data is caught in its slot.
  task wr(input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [31:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
    end
  endtask
  task mrd;
    begin
      @(posedge clk);
      mem_rd_valid <= 1'b1;
      @(posedge clk);
      mem_rd_valid <= 1'b0;
      #1 `CHK(mem_rvalid, 1'b1)
    end
  endtask
  task cnt_ref(input integer c);
    begin
      n = 0;
      repeat (c) @(posedge clk) n = n + refresh_cmd;
    end
  endtask
  task t_regs;
    begin
      rd(CP);
      `CHK(rd_val, 32'h64000001)
      rd(EC);
      `CHK(rd_val, 32'h01000000)
      wr(CP, 32'hfffffffe);
      rd(CP);
      `CHK(rd_val, 32'hff010001)
      wr(CP, 32'h00000001);
      rd(CP);
      `CHK(rd_val, 32'h00000000)
      // A refresh in progress may hold the inhibit back for one whole cycle.
      wr(EC, 32'hffffffff);
      repeat (12) @(posedge clk);
      rd(EC);
      `CHK(rd_val, 32'h071f0001)
      rd(32'hfef8002c);
      `CHK(rd_val, 32'h00000000)
      wr(EC, 32'h01000000);
    end
  endtask
  // A divisor of 5 must give exactly ten counter steps in fifty cycles.
  task t_tick;
    begin
      wr(CP, 32'hff000000);
      wr(CP, 32'h05000000);
      repeat (4) @(posedge clk);
      #1 rd_val = tick_count;
      repeat (50) @(posedge clk);
      #1 `CHK(tick_count - rd_val, 32'd10)
      n = tick_count;
      rd(`SDRTB_ADDR_TICK_COUNT);
      `CHK(rd_val - n <= 1, 1'b1)
    end
  endtask
  // Divisor 4 ticks every 4 cycles: 50 refreshes in 3120 cycles; twice that with
  // the divisor halved or with drr.
  task t_ref;
    begin
      wr(CP, 32'h04000000);
      cnt_ref(3120);
      `CHK(n >= 48 && n <= 52, 1'b1)
      wr(CP, 32'h02000000);
      cnt_ref(3120);
      `CHK(n >= 98 && n <= 102, 1'b1)
      wr(CP, 32'h04010000);
      cnt_ref(3120);
      `CHK(n >= 98 && n <= 102, 1'b1)
    end
  endtask
  // Inhibit is written during a refresh so the staged update is exercised.
  task t_refdis;
    begin
      n = 0;
      while (!refresh_cmd && n < 200) begin
        @(posedge clk);
        n++;
      end
      wr(EC, 32'h05000000);
      repeat (20) @(posedge clk);
      rd_val = tick_count;
      cnt_ref(300);
      `CHK(n, 0)
      `CHK(refresh_busy, 1'b0)
      `CHK(tick_count != rd_val, 1'b1)
      wr(EC, 32'h01000000);
    end
  endtask
  task t_irq;
    begin
      for (i = 0; i < 5; i++) begin
        wr(EC, 32'h01000000 | (32'h1 << (16 + i)));
        @(posedge clk) ev <= 5'h1 << i;
        @(posedge clk) ev <= 5'h0;
        #1 `CHK(irq, 1'b1)
        rd(ST);
        `CHK(rd_val, 32'h1 << i)
        wr(ST, 32'h1f);
        wr(EC, 32'h01008000);
        @(posedge clk) #1 `CHK(irq, 1'b0)
      end
      @(posedge clk) ev <= 5'h1f;
      @(posedge clk) ev <= 5'h0;
      repeat (2) @(posedge clk);
      #1 `CHK(irq, 1'b0)
      wr(EC, 32'h01000001);
      @(posedge clk) mbe_on_bus <= 1'b1;
      @(posedge clk) mbe_on_bus <= 1'b0;
      #1 `CHK(mchk_pulse, 1'b1)
    end
  endtask
  task t_mem;
    begin
      mrd;
      `CHK(mem_rdata, arr_data)
      wr(EC, 32'h0);
      mrd;
      `CHK(mem_rdata, corr_data)
      `CHK(merge_correct_en, 1'b1)
      wr(EC, 32'h03000000);
      @(posedge clk) mem_wr <= 1'b1;
      mem_wdata <= 64'hffeeddccbbaa9977;
      @(posedge clk) mem_wr <= 1'b0;
      #1 `CHK({data_wr, cb_wr}, 2'b01)
      `CHK(cb_wdata, 8'h77)
      mrd;
      `CHK(mem_rdata, 64'h77)
      `CHK(cb_access, 1'b1)
    end
  endtask
  task tally_and_finish;
    begin
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  // Reset is held for six cycles, then every scenario runs in turn.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_tick;
    t_ref;
    t_refdis;
    t_irq;
    t_mem;
    tally_and_finish;
  end
  // The run needs about 10000 cycles, so this limit only trips on a hang.
  initial begin
    #200000;
    failures++;
    tally_and_finish;
  end
endmodule
